// ### sar_ctrl_pkg.sv
// constants shared by the conversion control block
package sar_ctrl_pkg;
  // ==========================================================
  // resolution and codes
  localparam int RESOLUTION = 16;
  localparam logic [15:0] MIDSCALE_CODE = 16'h8000;
  localparam logic [15:0] RESET_CODE = 16'h0000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int THROUGHPUT_SPS = 250000;
  // one full cycle at the top rate, in clock cycles (longest, round down)
  localparam int CYCLE_CLKS = CLK_HZ / THROUGHPUT_SPS;
  // acquisition cycles left after conversion steps and wrap-up
  localparam int ACQ_CLKS = CYCLE_CLKS - RESOLUTION - 4;
  localparam logic [7:0] ACQ_COUNT = 8'(ACQ_CLKS);
  // ==========================================================
  // states, one-hot
  typedef enum logic [3:0] {
    ST_ACQ = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_CONV = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;
endpackage

// ### sar_conversion_control.sv
// control logic of a 16-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Contract
// R1 - convert only after acquisition and start low
// R2 - sixteen binary-weighted steps, most significant first
// R3 - form code, then drop busy
// R4 - straight binary or twos complement by select
// R5 - overrange saturates to top code
// R6 - underrange saturates to bottom code
// R7 - result belongs to same conversion, no latency
// R8 - cycle supports 250 kSPS; host keeps pace
// R9 - start high at acq end waits falling edge
// R10 - reset aborts any conversion
// R11 - power-down inhibits only after current conversion
// R12 - data bus driven only with select and read low
// R13 - busy high from start until code valid
module sar_conversion_control #(
  parameter int WIDTH = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CONVERT_START_N,
  input wire logic CODING_SELECT,
  input wire logic POWER_DOWN_IN,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_N,
  input wire logic COMPARATOR,
  input wire logic RESULT_READY,
  output logic SAMPLE_HOLD,
  output logic [WIDTH-1:0] DAC_CODE,
  output logic BUSY,
  output logic RESULT_VALID,
  output logic [WIDTH-1:0] DATA_OUT,
  output logic DATA_OE
);
  // ==========================================================
  // elaboration check
  if (WIDTH != sar_ctrl_pkg::RESOLUTION) begin : g_bad_width
    $error("width must equal converter resolution");
  end

  // ==========================================================
  // pin synchronisers, two flops each
  logic [4:0] sync1; // first stage, read only by sync2
  logic [4:0] sync2; // safe copies
  logic start_prev; // previous synced start level
  always_ff @(posedge CLK) begin
    sync1 <= {CONVERT_START_N, CODING_SELECT, POWER_DOWN_IN,
              CHIP_SELECT_N, READ_N};
    sync2 <= sync1;
  end
  wire start_n = sync2[4];
  wire coding = sync2[3];
  wire pd = sync2[2];
  wire cs_n = sync2[1];
  wire rd_n = sync2[0];

  // ==========================================================
  // conversion state
  sar_ctrl_pkg::state_t state, next_state;
  logic [7:0] acq_cnt, next_acq_cnt; // acquisition timer
  logic [4:0] bit_idx, next_bit_idx; // bit under test
  logic [WIDTH-1:0] trial, next_trial; // approximation register
  logic [WIDTH-1:0] code, next_code; // coded result
  logic busy, next_busy;
  logic hold, next_hold;
  logic push; // hand result to buffer

  // converts raw binary to the selected coding
  function automatic logic [WIDTH-1:0] encode(
    input logic [WIDTH-1:0] raw, input logic straight);
    // saturation falls out of the search: all ones or all zeros
    encode = straight ? raw : (raw ^ sar_ctrl_pkg::SIGN_FLIP); // R4 R5 R6
  endfunction

  // next-state logic
  always_comb begin
    next_state = state;
    next_acq_cnt = acq_cnt;
    next_bit_idx = bit_idx;
    next_trial = trial;
    next_code = code;
    next_busy = busy;
    next_hold = hold;
    push = 1'b0;
    case (state)
      sar_ctrl_pkg::ST_ACQ: begin
        // track input until the acquisition time passes
        if (acq_cnt != 8'h00) begin
          next_acq_cnt = acq_cnt - 8'h01; // R8
        end else if (!pd && !start_n) begin
          // start already low: hold at once
          next_state = sar_ctrl_pkg::ST_CONV; // R1 R9
        end else begin
          next_state = sar_ctrl_pkg::ST_WAIT; // R9
        end
      end
      sar_ctrl_pkg::ST_WAIT: begin
        // wait for a falling edge; power-down inhibits here
        if (!pd && !start_n && start_prev) begin
          next_state = sar_ctrl_pkg::ST_CONV; // R1 R9 R11
        end
      end
      sar_ctrl_pkg::ST_CONV: begin
        // keep the comparator result of the bit under test
        if (!COMPARATOR) begin
          next_trial[bit_idx[3:0]] = 1'b0; // R2
        end
        if (bit_idx == 5'h00) begin
          next_state = sar_ctrl_pkg::ST_DONE;
        end else begin
          next_bit_idx = bit_idx - 5'h01; // R2
          next_trial[bit_idx[3:0] - 4'h1] = 1'b1; // R2
        end
      end
      sar_ctrl_pkg::ST_DONE: begin
        // code formed from this conversion's own search
        next_code = encode(trial, coding); // R3 R7
        next_busy = 1'b0; // R3 R13
        push = 1'b1;
        next_hold = 1'b0;
        next_state = sar_ctrl_pkg::ST_ACQ;
        next_acq_cnt = sar_ctrl_pkg::ACQ_COUNT;
      end
      default: begin
        next_state = sar_ctrl_pkg::ST_ACQ;
      end
    endcase
    // entering conversion: seed msb, raise busy and hold
    if (next_state == sar_ctrl_pkg::ST_CONV &&
        state != sar_ctrl_pkg::ST_CONV) begin
      next_busy = 1'b1; // R13
      next_hold = 1'b1; // R7
      next_bit_idx = 5'(WIDTH - 1); // R2
      next_trial = sar_ctrl_pkg::MIDSCALE_CODE; // R2
    end
  end

  // state registers; reset aborts everything
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= sar_ctrl_pkg::ST_ACQ; // R10
      acq_cnt <= sar_ctrl_pkg::ACQ_COUNT;
      bit_idx <= 5'h00;
      trial <= sar_ctrl_pkg::RESET_CODE;
      code <= sar_ctrl_pkg::RESET_CODE;
      busy <= 1'b0; // R10
      hold <= 1'b0;
      start_prev <= 1'b1;
    end else begin
      state <= next_state;
      acq_cnt <= next_acq_cnt;
      bit_idx <= next_bit_idx;
      trial <= next_trial;
      code <= next_code;
      busy <= next_busy;
      hold <= next_hold;
      start_prev <= start_n;
    end
  end

  // ==========================================================
  // two-entry result buffer, drained when result is read
  logic [WIDTH-1:0] buf_data [2];
  logic [1:0] buf_cnt, next_buf_cnt;
  logic buf_rd, next_buf_rd; // head slot
  logic buf_wr, next_buf_wr; // tail slot
  logic pop; // reader takes head
  wire buf_ready = (buf_cnt != 2'h2);
  assign pop = (buf_cnt != 2'h0) && RESULT_READY;

  // buffer pointer logic; oldest word dropped if full
  always_comb begin
    next_buf_cnt = buf_cnt;
    next_buf_rd = buf_rd;
    next_buf_wr = buf_wr;
    if (pop) begin
      next_buf_rd = ~buf_rd;
    end
    if (push) begin
      next_buf_wr = ~buf_wr;
      if (!buf_ready && !pop) begin
        next_buf_rd = ~buf_rd;
      end
    end
    if (push && !pop && buf_ready) begin
      next_buf_cnt = buf_cnt + 2'h1;
    end else if (pop && !push) begin
      next_buf_cnt = buf_cnt - 2'h1;
    end
  end

  // buffer storage and pointers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      buf_cnt <= 2'h0;
      buf_rd <= 1'b0;
      buf_wr <= 1'b0;
    end else begin
      buf_cnt <= next_buf_cnt;
      buf_rd <= next_buf_rd;
      buf_wr <= next_buf_wr;
    end
    if (push) begin
      buf_data[buf_wr] <= next_code;
    end
  end

  // ==========================================================
  // output registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
      SAMPLE_HOLD <= 1'b0;
      DAC_CODE <= sar_ctrl_pkg::RESET_CODE;
      RESULT_VALID <= 1'b0;
      DATA_OUT <= sar_ctrl_pkg::RESET_CODE;
      DATA_OE <= 1'b0;
    end else begin
      BUSY <= next_busy; // R13
      SAMPLE_HOLD <= next_hold;
      DAC_CODE <= next_trial; // R2
      RESULT_VALID <= (next_buf_cnt != 2'h0);
      // a word written on this edge is not in storage yet: bypass it
      if (push && next_buf_rd == buf_wr) begin
        DATA_OUT <= next_code; // R3
      end else if (next_buf_cnt != 2'h0) begin
        DATA_OUT <= buf_data[next_buf_rd];
      end else begin
        DATA_OUT <= code;
      end
      DATA_OE <= !cs_n && !rd_n; // R12
    end
  end
endmodule
`default_nettype wire

// ### comparator_model.sv
// comparator stand-in: held analog level against the trial code
`timescale 1ns/1ps
`default_nettype none
module comparator_model (
  input wire logic [15:0] dac,
  input wire logic [16:0] level,
  output logic keep
);
  // keep the trial bit while the held level reaches it
  assign keep = (level >= {1'b0, dac});
endmodule
`default_nettype wire

// ### sar_ctrl_checker.sv
// port checker for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_checker #(
  parameter int WIDTH = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POWER_DOWN_IN,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_N,
  input wire logic SAMPLE_HOLD,
  input wire logic [WIDTH-1:0] DAC_CODE,
  input wire logic BUSY,
  input wire logic RESULT_VALID,
  input wire logic DATA_OE
);
  // ==========================================================
  // assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  busy_stays_a: assert property ($rose(BUSY) |-> BUSY[*8])
    else $error("busy dropped early");
  busy_ends_a: assert property ($rose(BUSY) |-> ##[15:18] !BUSY)
    else $error("conversion too long");
  msb_first_a: assert property ($rose(BUSY) |->
    SAMPLE_HOLD && DAC_CODE == sar_ctrl_pkg::MIDSCALE_CODE)
    else $error("first trial not msb");
  valid_end_a: assert property ($fell(BUSY) |-> RESULT_VALID)
    else $error("no result at busy fall");
  acq_gap_a: assert property ($fell(BUSY) |-> !BUSY[*8])
    else $error("restart without acquisition");
  pd_block_a: assert property (POWER_DOWN_IN[*5] |-> !$rose(BUSY))
    else $error("start while powered down");
  oe_on_a: assert property ((!CHIP_SELECT_N && !READ_N)[*4] |->
    DATA_OE)
    else $error("bus not enabled");
  oe_off_a: assert property ((CHIP_SELECT_N || READ_N)[*4] |->
    !DATA_OE)
    else $error("bus enabled wrongly");
  reset_clear_a: assert property ($fell(RESET) |->
    !BUSY && !RESULT_VALID && !SAMPLE_HOLD)
    else $error("state left after reset");
  // main scenarios
  cover property ($rose(BUSY));
  cover property ($fell(BUSY));
  cover property (DATA_OE);
endmodule
bind sar_conversion_control sar_ctrl_checker #(.WIDTH(WIDTH)) chk (
  .CLK(CLK), .RESET(RESET), .POWER_DOWN_IN(POWER_DOWN_IN),
  .CHIP_SELECT_N(CHIP_SELECT_N), .READ_N(READ_N),
  .SAMPLE_HOLD(SAMPLE_HOLD), .DAC_CODE(DAC_CODE), .BUSY(BUSY),
  .RESULT_VALID(RESULT_VALID), .DATA_OE(DATA_OE));
`default_nettype wire

// ### tb.sv
// bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb;
  logic CLK = 0, RESET = 1, CONVERT_START_N = 1, CODING_SELECT = 1;
  logic POWER_DOWN_IN = 0, CHIP_SELECT_N = 1, READ_N = 1;
  logic RESULT_READY = 0;
  logic COMPARATOR, SAMPLE_HOLD, BUSY, RESULT_VALID, DATA_OE;
  logic [15:0] DAC_CODE, DATA_OUT;
  logic [16:0] level = 0; // held input, top bit means overrange
  int fails = 0, num_checks = 0;
  always #10 CLK = ~CLK;
  sar_conversion_control uut (.CLK(CLK), .RESET(RESET),
    .CONVERT_START_N(CONVERT_START_N), .CODING_SELECT(CODING_SELECT),
    .POWER_DOWN_IN(POWER_DOWN_IN), .CHIP_SELECT_N(CHIP_SELECT_N),
    .READ_N(READ_N), .COMPARATOR(COMPARATOR),
    .RESULT_READY(RESULT_READY), .SAMPLE_HOLD(SAMPLE_HOLD),
    .DAC_CODE(DAC_CODE), .BUSY(BUSY), .RESULT_VALID(RESULT_VALID),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  comparator_model far (.dac(DAC_CODE), .level(level), .keep(COMPARATOR));
  // verdict and end of run
  task summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for busy to reach a level
  task wt(input logic lvl);
    int n;
    n = 0;
    while (BUSY !== lvl) begin
      @(negedge CLK);
      n++;
      if (n > 400) begin
        fails++;
        summarize();
      end
    end
  endtask
  // one conversion, then rest out the cycle
  task conv(input logic [16:0] v);
    level = v;
    CONVERT_START_N = 0;
    wt(1);
    CONVERT_START_N = 1;
    wt(0);
    repeat (190) @(negedge CLK);
  endtask
  // take the buffer head and compare it
  task pop(input logic [15:0] e);
    `CHK(RESULT_VALID, 1'b1)
    `CHK(DATA_OUT, e)
    RESULT_READY = 1;
    @(negedge CLK);
    RESULT_READY = 0;
    // let one edge pass before any further pop
    @(negedge CLK);
  endtask
  initial begin
    repeat (12) @(negedge CLK);
    RESET = 0;
    conv(17'h08000);
    CODING_SELECT = 0;
    conv(17'h08000);
    pop(16'h8000);
    pop(16'h0000);
    `CHK(RESULT_VALID, 1'b0)
    conv(17'h1ffff);
    pop(16'h7fff);
    conv(17'h00000);
    pop(16'h8000);
    CODING_SELECT = 1;
    conv(17'h1ffff);
    pop(16'hffff);
    conv(17'h00000);
    pop(16'h0000);
    conv(17'h01234);
    `CHK(RESULT_VALID, 1'b1)
    `CHK(DATA_OUT, 16'h1234)
    // abort a conversion in flight, one word still buffered
    CONVERT_START_N = 0;
    wt(1);
    RESET = 1;
    repeat (2) @(negedge CLK);
    `CHK(BUSY, 1'b0)
    `CHK(RESULT_VALID, 1'b0)
    RESET = 0;
    // start stays low: conversion runs once acquisition ends
    wt(1);
    // power-down lets the running conversion finish
    POWER_DOWN_IN = 1;
    CONVERT_START_N = 1;
    wt(0);
    pop(16'h1234);
    CONVERT_START_N = 0;
    repeat (300) @(negedge CLK);
    `CHK(RESULT_VALID, 1'b0)
    // output bus enable
    CHIP_SELECT_N = 0;
    READ_N = 0;
    repeat (5) @(negedge CLK);
    `CHK(DATA_OE, 1'b1)
    READ_N = 1;
    repeat (5) @(negedge CLK);
    `CHK(DATA_OE, 1'b0)
    summarize();
  end
endmodule
`default_nettype wire
